// ---- cgw_guard.sv ----
// Code segment write guard: configuration hold with shadow check, write/erase range check, APB registers.
// Assumes the flash controller waits for op_go or op_block before touching flash.
//
// Behaviour
// - Every configuration bit has a complemented shadow that is compared with it on every cycle.
// - A configuration bit that changes on its own is a parity error and raises a full device reset.
// - The configuration is loaded from the stored configuration words, and a set code-protect bit denies all external access.
// - With segment protection disabled only the global code-protect and write-protect bits govern flash.
// - Enabled with end select 1, the boundary page through the end of memory is blocked, configuration page included.
// - Enabled with end select 0 and config-page protect 1, address zero through the boundary page is blocked.
// - Enabled with both bits 0, the bottom range and also the last page holding the configuration words are blocked.
// - While debugging, two pins and the lowest 80 bytes of data RAM are held for the debug function.
// - Debug clock and data go to the single pin pair picked by the channel select bits.
// - The 8-bit boundary field names one 512-word page that is the inclusive start or end of the segment.
// - A write or erase is blocked when either the global write protect or the segment check forbids it.
// - A global write-protect bit of 0 blocks every internal write and erase.
//
// Local design decisions: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module cgw_guard
    import cgw_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Configuration word load from flash
    input wire logic cfg_load,
    input wire logic [15:0] cfg_word,
    // Write and erase requests from the flash controller
    input wire logic op_req,
    input wire logic [ADDR_W-1:0] op_addr,
    output logic op_go,
    output logic op_block,
    // External programming access
    input wire logic ext_req,
    output logic ext_grant,
    output logic ext_deny,
    // Debug core side
    input wire logic dbg_data_o,
    input wire logic dbg_data_oe,
    output logic dbg_clk_i,
    output logic dbg_data_i,
    // Debug pin pairs
    input wire logic [NUM_PAIRS-1:0] debug_clock_pin_i,
    input wire logic [NUM_PAIRS-1:0] debug_data_pin_i,
    output logic [NUM_PAIRS-1:0] debug_data_pin_o,
    output logic [NUM_PAIRS-1:0] debug_data_pin_oe,
    // Data RAM reservation
    input wire logic [15:0] ram_addr,
    output logic ram_reserved,
    // System
    output logic irq,
    output logic dev_reset_req
);
    typedef struct packed {
        cgw_state_e st;
        logic [CFG_W-1:0] live;
        logic [CFG_W-1:0] shadow;
        logic [IRQ_W-1:0] ist;
        logic [IRQ_W-1:0] imask;
        logic dbg_en;
        logic [ADDR_W-1:0] blk_addr;
        logic [15:0] blk_cnt;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic op_go;
        logic op_block;
        logic ext_grant;
        logic ext_deny;
        logic irq;
        logic rst_req;
    } cgw_state_s;

    localparam cgw_state_s STATE_RESET = '{
        st: ST_UNLOADED,
        live: CFG_RESET,
        shadow: ~CFG_RESET,
        ist: IRQ_RESET,
        imask: IRQ_RESET,
        default: '0
    };

    cgw_state_s s_q;
    cgw_state_s s_d;
    cgw_cfg_if cfg_bus ();

    // Segment decision for one address under one configuration.
    function automatic logic seg_block(input logic [CFG_W-1:0] c, input logic [ADDR_W-1:0] a);
        logic [CFG_BP_W-1:0] page;
        logic [CFG_BP_W-1:0] bp;
        logic hit;
        page = a[PAGE_LSB +: CFG_BP_W];
        bp = c[CFG_BP_LSB +: CFG_BP_W];
        hit = 1'b0;
        if (c[CFG_DIS]) begin
            hit = 1'b0;
        end else if (c[CFG_END]) begin
            hit = (page >= bp);
        end else if (c[CFG_PGP]) begin
            hit = (page <= bp);
        end else begin
            hit = (page <= bp) || (page == LAST_PAGE);
        end
        return hit;
    endfunction : seg_block

    // Full write/erase decision: segment protection only ever adds.
    function automatic logic wr_block(input logic [CFG_W-1:0] c, input logic [ADDR_W-1:0] a);
        return !c[CFG_GWP] || seg_block(c, a);
    endfunction : wr_block

    logic apb_setup;
    logic apb_write;
    logic mapped;
    logic [IRQ_W-1:0] ev_set;
    logic [IRQ_W-1:0] ev_clr;
    logic deny_op;

    assign apb_setup = psel && !penable;
    assign apb_write = psel && penable && s_q.pready && pwrite && !s_q.pslverr;
    assign mapped = (paddr == OFS_CFG) || (paddr == OFS_IRQ_STAT) || (paddr == OFS_IRQ_MASK)
        || (paddr == OFS_CTRL) || (paddr == OFS_BLK_ADDR) || (paddr == OFS_UPSET)
        || (paddr == OFS_BLK_CNT);
    assign cfg_bus.live = s_q.live;
    assign cfg_bus.shadow = s_q.shadow;
    assign cfg_bus.loaded = (s_q.st != ST_UNLOADED);
    // Until a good configuration stands, every write is refused; erased flash must not mean open.
    assign deny_op = (s_q.st != ST_RUN) || wr_block(s_q.live, op_addr);

    always_comb begin
        s_d = s_q;
        ev_set = '0;
        ev_clr = '0;
        s_d.op_go = 1'b0;
        s_d.op_block = 1'b0;
        s_d.ext_grant = 1'b0;
        s_d.ext_deny = 1'b0;

        // Configuration life cycle.
        case (s_q.st)
            ST_UNLOADED: begin
                if (cfg_load) begin
                    s_d.live = cfg_word;
                    s_d.shadow = ~cfg_word;
                    s_d.st = ST_RUN;
                end
            end
            ST_RUN: begin
                if (cfg_bus.mismatch) begin
                    s_d.st = ST_FAULT;
                    ev_set[IRQ_PAR] = 1'b1;
                end else if (cfg_load) begin
                    s_d.live = cfg_word;
                    s_d.shadow = ~cfg_word;
                end
            end
            ST_FAULT: begin
                s_d.rst_req = 1'b1;
            end
            default: begin
                s_d.st = ST_FAULT;
            end
        endcase

        // Write and erase screening, one cycle ahead of the operation.
        if (op_req) begin
            if (deny_op) begin
                s_d.op_block = 1'b1;
                s_d.blk_addr = op_addr;
                s_d.blk_cnt = s_q.blk_cnt + 16'h0001;
                ev_set[IRQ_BLK] = 1'b1;
            end else begin
                s_d.op_go = 1'b1;
            end
        end

        // External reads and writes, including the configuration words.
        if (ext_req) begin
            if (s_q.live[CFG_GCP] || (s_q.st != ST_RUN)) begin
                s_d.ext_deny = 1'b1;
                ev_set[IRQ_EXT] = 1'b1;
            end else begin
                s_d.ext_grant = 1'b1;
            end
        end

        // APB: answer ready in the access cycle, read data captured at setup.
        s_d.pready = apb_setup;
        if (apb_setup) begin
            s_d.pslverr = !mapped;
            s_d.prdata = '0;
            case (paddr)
                OFS_CFG: s_d.prdata = {16'h0000, s_q.live};
                OFS_IRQ_STAT: s_d.prdata = {29'h0, s_q.ist};
                OFS_IRQ_MASK: s_d.prdata = {29'h0, s_q.imask};
                OFS_CTRL: s_d.prdata = {31'h0, s_q.dbg_en};
                OFS_BLK_ADDR: s_d.prdata = {15'h0, s_q.blk_addr};
                OFS_BLK_CNT: s_d.prdata = {16'h0000, s_q.blk_cnt};
                default: s_d.prdata = '0;
            endcase
        end else begin
            s_d.pslverr = 1'b0;
        end

        if (apb_write) begin
            case (paddr)
                OFS_IRQ_STAT: ev_clr = pwdata[IRQ_W-1:0];
                OFS_IRQ_MASK: s_d.imask = pwdata[IRQ_W-1:0];
                OFS_CTRL: s_d.dbg_en = pwdata[0];
                // Flips live bits without the shadow so the upset path can be exercised.
                OFS_UPSET: s_d.live = s_d.live ^ pwdata[CFG_W-1:0];
                default: s_d.live = s_d.live;
            endcase
        end

        // A new event wins over a clear in the same cycle.
        s_d.ist = (s_q.ist & ~ev_clr) | ev_set;
        s_d.irq = |(s_d.ist & s_d.imask);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= STATE_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    cgw_shadow_chk u_chk (
        .pclk(pclk),
        .presetn(presetn),
        .cfg(cfg_bus)
    );

    cgw_dbg_route u_route (
        .pclk(pclk),
        .presetn(presetn),
        .en(s_q.dbg_en),
        .sel(s_q.live[CFG_ICS_LSB +: 2]),
        .core_data_o(dbg_data_o),
        .core_data_oe(dbg_data_oe),
        .core_clk_i(dbg_clk_i),
        .core_data_i(dbg_data_i),
        .pin_clk_i(debug_clock_pin_i),
        .pin_data_i(debug_data_pin_i),
        .pin_data_o(debug_data_pin_o),
        .pin_data_oe(debug_data_pin_oe),
        .ram_addr(ram_addr),
        .ram_reserved(ram_reserved)
    );

    assign prdata = s_q.prdata;
    assign pready = s_q.pready;
    assign pslverr = s_q.pslverr;
    assign op_go = s_q.op_go;
    assign op_block = s_q.op_block;
    assign ext_grant = s_q.ext_grant;
    assign ext_deny = s_q.ext_deny;
    assign irq = s_q.irq;
    assign dev_reset_req = s_q.rst_req;
endmodule : cgw_guard
`default_nettype wire

// ---- cgw_pkg.sv ----
// Shared constants and types of the code segment write guard.
// Assumes a 100 MHz APB clock and word addresses from the flash controller.
package cgw_pkg;
    // Register offsets, byte addresses on APB.
    localparam logic [7:0] OFS_CFG = 8'h00;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h04;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h08;
    localparam logic [7:0] OFS_CTRL = 8'h0c;
    localparam logic [7:0] OFS_BLK_ADDR = 8'h10;
    localparam logic [7:0] OFS_UPSET = 8'h14;
    localparam logic [7:0] OFS_BLK_CNT = 8'h18;
    // Configuration word layout.
    localparam int CFG_W = 16;
    localparam int CFG_BP_LSB = 0;
    localparam int CFG_BP_W = 8;
    localparam int CFG_END = 8;
    localparam int CFG_PGP = 9;
    localparam int CFG_DIS = 10;
    localparam int CFG_GWP = 11;
    localparam int CFG_GCP = 12;
    localparam int CFG_ICS_LSB = 13;
    localparam logic [15:0] CFG_RESET = 16'hffff;
    // Program memory geometry in words.
    localparam int ADDR_W = 17;
    localparam int PAGE_LSB = 9;
    localparam logic [7:0] LAST_PAGE = 8'hff;
    // Debug resources.
    localparam int NUM_PAIRS = 3;
    localparam logic [15:0] RES_RAM_BYTES = 16'h0050;
    // Interrupt status bits.
    localparam int IRQ_W = 3;
    localparam int IRQ_BLK = 0;
    localparam int IRQ_PAR = 1;
    localparam int IRQ_EXT = 2;
    localparam logic [2:0] IRQ_RESET = 3'h0;
    typedef enum logic [1:0] {
        ST_UNLOADED = 2'b00,
        ST_RUN = 2'b01,
        ST_FAULT = 2'b11
    } cgw_state_e;
endpackage : cgw_pkg

// ---- cgw_cfg_if.sv ----
// Carrier for the live configuration, its shadow and the compare result.
// Assumes both ends share pclk.
`timescale 1ns/1ps
`default_nettype none
interface cgw_cfg_if;
    logic [15:0] live;
    logic [15:0] shadow;
    logic loaded;
    logic mismatch;
    modport owner (output live, output shadow, output loaded, input mismatch);
    modport cmp (input live, input shadow, input loaded, output mismatch);
endinterface : cgw_cfg_if
`default_nettype wire

// ---- cgw_shadow_chk.sv ----
// Continuous compare of the live configuration against its complement shadow.
// Assumes the owner loads both copies in the same cycle.
`timescale 1ns/1ps
`default_nettype none
module cgw_shadow_chk
    import cgw_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Configuration carrier
    cgw_cfg_if.cmp cfg
);
    typedef struct packed {
        logic mism;
    } cgw_chk_s;
    cgw_chk_s s_q;
    cgw_chk_s s_d;
    always_comb begin
        s_d = s_q;
        s_d.mism = cfg.loaded && (cfg.live != ~cfg.shadow);
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
    assign cfg.mismatch = s_q.mism;
endmodule : cgw_shadow_chk
`default_nettype wire

// ---- cgw_dbg_route.sv ----
// Debug pin pair routing and reservation of low data RAM while debugging.
// Assumes pin inputs are synchronous to pclk.
`timescale 1ns/1ps
`default_nettype none
module cgw_dbg_route
    import cgw_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Control
    input wire logic en,
    input wire logic [1:0] sel,
    // Debug core side
    input wire logic core_data_o,
    input wire logic core_data_oe,
    output logic core_clk_i,
    output logic core_data_i,
    // Pins
    input wire logic [NUM_PAIRS-1:0] pin_clk_i,
    input wire logic [NUM_PAIRS-1:0] pin_data_i,
    output logic [NUM_PAIRS-1:0] pin_data_o,
    output logic [NUM_PAIRS-1:0] pin_data_oe,
    // Data RAM
    input wire logic [15:0] ram_addr,
    output logic ram_reserved
);
    typedef struct packed {
        logic [NUM_PAIRS-1:0] dout;
        logic [NUM_PAIRS-1:0] doe;
        logic cclk;
        logic cdat;
        logic rres;
    } cgw_route_s;
    cgw_route_s s_q;
    cgw_route_s s_d;
    logic [NUM_PAIRS-1:0] hit;
    genvar i;
    generate
        for (i = 0; i < NUM_PAIRS; i++) begin : g_pair
            assign hit[i] = en && (sel == 2'(i));
        end
    endgenerate
    always_comb begin
        s_d = s_q;
        s_d.dout = hit & {NUM_PAIRS{core_data_o}};
        s_d.doe = hit & {NUM_PAIRS{core_data_oe}};
        s_d.cclk = |(hit & pin_clk_i);
        s_d.cdat = |(hit & pin_data_i);
        s_d.rres = en && (ram_addr < RES_RAM_BYTES);
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
    assign pin_data_o = s_q.dout;
    assign pin_data_oe = s_q.doe;
    assign core_clk_i = s_q.cclk;
    assign core_data_i = s_q.cdat;
    assign ram_reserved = s_q.rres;
endmodule : cgw_dbg_route
`default_nettype wire

// ---- cgw_guard_asserts.sv ----
// Concurrent checks on the write guard top ports.
// Assumes it is bound to every cgw_guard instance.
`timescale 1ns/1ps
`default_nettype none
module cgw_guard_asserts
    import cgw_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Inputs
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic cfg_load,
    input wire logic [15:0] cfg_word,
    input wire logic op_req,
    input wire logic [ADDR_W-1:0] op_addr,
    input wire logic ext_req,
    input wire logic [NUM_PAIRS-1:0] debug_clock_pin_i,
    input wire logic [15:0] ram_addr,
    // Outputs
    input wire logic pready,
    input wire logic op_go,
    input wire logic op_block,
    input wire logic ext_grant,
    input wire logic ext_deny,
    input wire logic dbg_clk_i,
    input wire logic ram_reserved,
    input wire logic dev_reset_req
);
    logic [15:0] cfg_q;
    logic ld_q;
    logic up_q;
    logic en_q;
    logic wr;
    logic ok;
    logic hit;
    logic [7:0] pg;
    assign wr = psel && penable && pready && pwrite;
    assign ok = ld_q && !up_q;
    assign pg = op_addr[ADDR_W-1:PAGE_LSB];
    assign hit = !cfg_q[CFG_DIS] && (cfg_q[CFG_END] ? pg >= cfg_q[7:0]
        : (pg <= cfg_q[7:0] || (!cfg_q[CFG_PGP] && pg == LAST_PAGE)));
    // The mirror stops following loads once an upset is injected, as the design leaves run mode.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_q <= CFG_RESET;
            ld_q <= 1'b0;
            up_q <= 1'b0;
            en_q <= 1'b0;
        end else begin
            if (cfg_load && !up_q) begin
                cfg_q <= cfg_word;
                ld_q <= 1'b1;
            end
            if (wr && paddr == OFS_UPSET && pwdata[15:0] != 16'h0 && ld_q) begin
                up_q <= 1'b1;
            end
            if (wr && paddr == OFS_CTRL) begin
                en_q <= pwdata[0];
            end
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_op_one_answer: assert property (op_req |=> op_go != op_block) else $error("op answer wrong");
    a_op_has_cause: assert property ((op_go || op_block) |-> $past(op_req)) else $error("op answer unasked");
    a_unloaded_blocks: assert property (op_req && !ld_q |=> op_block) else $error("op before load");
    a_gwp_blocks: assert property (op_req && !cfg_q[CFG_GWP] |=> op_block) else $error("gwp not obeyed");
    a_segment_range: assert property (op_req && ok && cfg_q[CFG_GWP]
        |=> op_block == $past(hit)) else $error("segment range wrong");
    a_ext_deny: assert property (ext_req && (!ld_q || (!up_q && cfg_q[CFG_GCP])) |=> ext_deny && !ext_grant)
        else $error("ext not denied");
    a_ext_grant: assert property (ext_req && ok && !cfg_q[CFG_GCP] |=> ext_grant) else $error("ext not granted");
    a_upset_reset: assert property (wr && paddr == OFS_UPSET && pwdata[15:0] != 16'h0 && ok
        |-> ##[1:6] dev_reset_req) else $error("upset not caught");
    a_reset_sticky: assert property (dev_reset_req |=> dev_reset_req) else $error("reset dropped");
    a_ram_reserve: assert property (1'b1 |=> ram_reserved == $past(en_q && ram_addr < RES_RAM_BYTES))
        else $error("ram reserve wrong");
    a_pin_route: assert property (en_q && ok && cfg_q[14:13] != 2'b11
        |=> dbg_clk_i == $past(debug_clock_pin_i[cfg_q[14:13]])) else $error("debug route wrong");
    c_go: cover property (op_req ##1 op_go);
    c_block: cover property (op_req ##1 op_block);
    c_fault: cover property ($rose(dev_reset_req));
endmodule : cgw_guard_asserts
bind cgw_guard cgw_guard_asserts u_asserts (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .cfg_load(cfg_load), .cfg_word(cfg_word), .op_req(op_req),
    .op_addr(op_addr), .ext_req(ext_req), .debug_clock_pin_i(debug_clock_pin_i), .ram_addr(ram_addr),
    .pready(pready), .op_go(op_go), .op_block(op_block), .ext_grant(ext_grant), .ext_deny(ext_deny),
    .dbg_clk_i(dbg_clk_i), .ram_reserved(ram_reserved), .dev_reset_req(dev_reset_req));
`default_nettype wire

// ---- cgw_flash_model.sv ----
// Flash programming controller model facing the guard request port.
// Assumes the bench asks for at most one request per cycle.
`timescale 1ns/1ps
`default_nettype none
module cgw_flash_model
    import cgw_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Bench side
    input wire logic go_i,
    input wire logic [ADDR_W-1:0] addr_i,
    output logic [15:0] writes,
    // Guard side
    output logic op_req,
    output logic [ADDR_W-1:0] op_addr,
    input wire logic op_go
);
    // The idle address flips every cycle so a stale value never passes for a request.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            op_req <= 1'b0;
            op_addr <= '0;
            writes <= 16'h0;
        end else begin
            op_req <= go_i;
            op_addr <= go_i ? addr_i : ~op_addr;
            if (op_go) begin
                writes <= writes + 16'h1;
            end
        end
    end
endmodule : cgw_flash_model
`default_nettype wire

// ---- cgw_guard_test.sv ----
// Self-checking bench of the code segment write guard.
// Assumes the checker binds itself and the flash model drives the request port.
`timescale 1ns/1ps
`default_nettype none
module cgw_guard_test
    import cgw_pkg::*;
;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, cfg_load, fgo, op_req, op_go, op_block;
    logic ext_req, ext_grant, ext_deny, d_o, d_oe, dbg_clk_i, dbg_data_i, ram_reserved, irq, dev_reset_req;
    logic [7:0] paddr, bp;
    logic [31:0] pwdata, prdata;
    logic [15:0] cfg_word, ram_addr, writes, cfg;
    logic [ADDR_W-1:0] op_addr, faddr, last_blk;
    logic [NUM_PAIRS-1:0] pck, pdt, pdo, pdoe;
    logic [7:0] pl[6];
    logic [32:0] rd_q[$];
    logic op_q[$];
    logic ld, flt, den;
    logic [2:0] dq;
    int n_fail, num_checks, n_go, n_blk, i;
    cgw_guard i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .cfg_load(cfg_load),
        .cfg_word(cfg_word), .op_req(op_req), .op_addr(op_addr), .op_go(op_go), .op_block(op_block),
        .ext_req(ext_req), .ext_grant(ext_grant), .ext_deny(ext_deny), .dbg_data_o(d_o), .dbg_data_oe(d_oe),
        .dbg_clk_i(dbg_clk_i), .dbg_data_i(dbg_data_i), .debug_clock_pin_i(pck), .debug_data_pin_i(pdt),
        .debug_data_pin_o(pdo), .debug_data_pin_oe(pdoe), .ram_addr(ram_addr), .ram_reserved(ram_reserved),
        .irq(irq), .dev_reset_req(dev_reset_req));
    cgw_flash_model i_flash (.pclk(pclk), .presetn(presetn), .go_i(fgo), .addr_i(faddr), .writes(writes),
        .op_req(op_req), .op_addr(op_addr), .op_go(op_go));
    task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : end_of_test
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        if (!w) rd_q.push_back(e);
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (!pready && k < 20);
        if (k >= 20) begin
            n_fail++;
            end_of_test();
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    function automatic logic blk(input logic [15:0] c, input logic [ADDR_W-1:0] a);
        logic [7:0] p;
        logic s;
        p = a[ADDR_W-1:PAGE_LSB];
        s = c[CFG_END] ? p >= c[7:0] : (p <= c[7:0] || (!c[CFG_PGP] && p == 8'hff));
        return !ld || flt || !c[CFG_GWP] || (!c[CFG_DIS] && s);
    endfunction : blk
    task automatic op(input logic [ADDR_W-1:0] a);
        logic b;
        b = blk(cfg, a);
        @(posedge pclk);
        fgo <= 1'b1;
        faddr <= a;
        op_q.push_back(b);
        if (b) begin
            n_blk++;
            last_blk = a;
        end else n_go++;
    endtask : op
    task automatic idle(input int n);
        @(posedge pclk);
        fgo <= 1'b0;
        ext_req <= 1'b0;
        cfg_load <= 1'b0;
        repeat (n) @(posedge pclk);
    endtask : idle
    always @(posedge pclk) begin
        // Pair 1 is selected, so only its lane may carry the core's data of the previous cycle.
        if (den) chk(33'({pdo, pdoe, dbg_data_i}), 33'({1'b0, dq[2], 2'b00, dq[1], 1'b0, dq[0]}));
        dq <= {d_o, d_oe, pdt[1]};
        pck <= NUM_PAIRS'($urandom);
        pdt <= NUM_PAIRS'($urandom);
        d_o <= 1'($urandom);
        d_oe <= 1'($urandom);
        if (psel && penable && pready && !pwrite) begin
            if (rd_q.size() > 0) chk({pslverr, prdata}, rd_q.pop_front());
            else n_fail++;
        end
        if (op_go || op_block) begin
            if (op_q.size() > 0) chk(33'({op_go, op_block}), 33'({!op_q[0], op_q[0]}));
            else n_fail++;
            if (op_q.size() > 0) op_q.pop_front();
        end
    end
    initial begin
        {presetn, psel, penable, pwrite, cfg_load, fgo, ext_req, ld, flt, den} = '0;
        {paddr, pwdata, cfg_word, ram_addr, faddr, pck, pdt, d_o, d_oe} = '0;
        cfg = CFG_RESET;
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    initial begin
        repeat (30000) @(posedge pclk);
        n_fail++;
        end_of_test();
    end
    initial begin
        void'($urandom(32'h8aa0));
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, OFS_CFG, 0, {17'h0, CFG_RESET});
        apb(0, OFS_IRQ_MASK, 0, 33'h0);
        apb(0, 8'h1c, 0, {1'b1, 32'h0});
        op(17'h0);
        op(17'h1ffff);
        idle(2);
        $display("reset test done");
        for (int m = 0; m < 9; m++) begin
            bp = 8'($urandom_range(254, 1));
            pl = '{8'h0, bp - 8'h1, bp, bp + 8'h1, 8'hfe, 8'hff};
            cfg = {1'b0, 2'b01, m[0], m < 8, m[2], m[1], m[0], bp};
            @(posedge pclk);
            cfg_load <= 1'b1;
            cfg_word <= cfg;
            ld = 1'b1;
            ext_req <= 1'b1;
            @(posedge pclk);
            cfg_load <= 1'b0;
            ext_req <= 1'b1;
            @(posedge pclk);
            ext_req <= 1'b0;
            @(posedge pclk);
            chk(33'({ext_grant, ext_deny}), 33'({!cfg[CFG_GCP], cfg[CFG_GCP]}));
            for (int k = 0; k < 10; k++) op({k < 6 ? pl[k] : 8'($urandom), 9'($urandom)});
            idle(3);
        end
        apb(0, OFS_BLK_CNT, 0, 33'(n_blk));
        apb(0, OFS_BLK_ADDR, 0, 33'(last_blk));
        chk(33'(writes), 33'(n_go));
        $display("segment test done");
        apb(1, OFS_CFG, 0, 0);
        apb(0, OFS_CFG, 0, 33'(cfg));
        apb(1, OFS_IRQ_MASK, 32'h1, 0);
        idle(1);
        chk(33'(irq), 33'h1);
        apb(1, OFS_IRQ_STAT, 32'h7, 0);
        idle(1);
        chk(33'(irq), 33'h0);
        apb(1, OFS_IRQ_MASK, 32'h0, 0);
        op(17'h0);
        idle(2);
        chk(33'(irq), 33'h0);
        apb(0, OFS_IRQ_STAT, 0, 33'h1);
        $display("interrupt test done");
        apb(1, OFS_CTRL, 32'h1, 0);
        for (int k = 0; k < 2; k++) begin
            @(posedge pclk);
            den <= 1'b1;
            ram_addr <= 16'h004f + 16'(k);
            repeat (2) @(posedge pclk);
            chk(33'(ram_reserved), 33'(k == 0));
        end
        $display("debug test done");
        apb(1, OFS_UPSET, 32'h1, 0);
        i = 0;
        while (!dev_reset_req && i < 10) begin
            @(posedge pclk);
            i++;
        end
        chk(33'(dev_reset_req), 33'h1);
        flt = 1'b1;
        apb(0, OFS_IRQ_STAT, 0, 33'h3);
        op(17'h1fe00);
        idle(2);
        $display("upset test done");
        den <= 1'b0;
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        {ld, flt} = '0;
        apb(0, OFS_CFG, 0, {17'h0, CFG_RESET});
        chk(33'(dev_reset_req), 33'h0);
        idle(3);
        $display("second reset test done");
        end_of_test();
    end
endmodule : cgw_guard_test
`default_nettype wire
